// File: rtl/hub_power_port_config_bytes.sv
// configuration byte bank for hub power mode, port disables and current limits
// Functional notes
// [RULE1] dynamic bit enables automatic self/bus switching
// [RULE2] two-bit field selects overcurrent delay
// [RULE3] compound bit marks hub in compound device
// [RULE4] port bits mark non-removable devices
// [RULE5] reserved port byte bits read zero
// [RULE6] self-powered disable byte turns ports off
// [RULE7] bus-powered disable byte turns ports off
// [RULE8] self-powered current figure in 2 mA units
// [RULE9] bus-powered current figure in 2 mA units
// [RULE10] loader adds embedded peripheral to current figures; cfg_loader writes them unchanged apart from the self-powered clamp
// [RULE11] loader keeps self-powered figure at most 50
// [RULE12] dynamic mode follows sense pin, not select bit
// [RULE13] active mode picks disable and current bytes
module hub_power_port_config_bytes #(
    parameter int OC_CYC_0 = hub_cfg_pkg::OC_CYC0,
    parameter int OC_CYC_1 = hub_cfg_pkg::OC_CYC1,
    parameter int OC_CYC_2 = hub_cfg_pkg::OC_CYC2,
    parameter int OC_CYC_3 = hub_cfg_pkg::OC_CYC3
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // configuration byte port from the loader
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    // power source inputs
    input  wire logic       power_source_select,
    input  wire logic       local_power_sense_pin,
    // overcurrent event from port power switch, already on mclk
    input  wire logic       oc_raw,
    // decoded outputs to the hub core
    output logic            self_powered,
    output logic            compound_device,
    output logic      [2:1] fixed_device_port_mask,
    output logic      [2:1] port_off,
    output logic      [7:0] current_limit,
    output logic            oc_fault
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  options;
        logic [7:0]  fixed_ports;
        logic [7:0]  self_off;
        logic [7:0]  bus_off;
        logic [7:0]  self_limit;
        logic [7:0]  bus_limit;
        logic [1:0]  sense_sync;
        logic        self_pw;
        logic [2:1]  port_off;
        logic [7:0]  limit;
        logic        compound;
        logic [2:1]  fixed;
        logic [7:0]  rdata;
        logic [31:0] oc_cnt;
        logic        oc_fault;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic [31:0] oc_target;

    ////////////////////////////////////////////////////////////////////
    // delay select decode
    always_comb begin
        unique case (st_q.options[hub_cfg_pkg::OC_SEL_LSB +: 2]) // see [RULE2]
            2'b00: oc_target = 32'(OC_CYC_0);
            2'b01: oc_target = 32'(OC_CYC_1);
            2'b10: oc_target = 32'(OC_CYC_2);
            2'b11: oc_target = 32'(OC_CYC_3);
        endcase
    end

    // next state: writes, mode selection, readback
    always_comb begin
        st_d = st_q;
        st_d.sense_sync = {st_q.sense_sync[0], local_power_sense_pin};
        if (cfg_wr) begin
            unique case (cfg_addr)
                hub_cfg_pkg::OFF_HUB_OPTIONS_TWO:
                    st_d.options = cfg_wdata & hub_cfg_pkg::OPTIONS_MASK;
                hub_cfg_pkg::OFF_FIXED_DEVICE_PORTS:
                    st_d.fixed_ports = cfg_wdata & hub_cfg_pkg::PORT_BITS_MASK; // see [RULE5]
                hub_cfg_pkg::OFF_PORT_OFF_SELF_POWER:
                    st_d.self_off = cfg_wdata & hub_cfg_pkg::PORT_BITS_MASK;
                hub_cfg_pkg::OFF_PORT_OFF_BUS_POWER:
                    st_d.bus_off = cfg_wdata & hub_cfg_pkg::PORT_BITS_MASK;
                hub_cfg_pkg::OFF_POWER_LIMIT_SELF:
                    st_d.self_limit = cfg_wdata; // see [RULE8]
                hub_cfg_pkg::OFF_POWER_LIMIT_BUS:
                    st_d.bus_limit = cfg_wdata; // see [RULE9]
                default: ;
            endcase
        end
        // dynamic mode follows the synchronised sense pin, else the select bit
        if (st_q.options[hub_cfg_pkg::DYNAMIC_BIT])
            st_d.self_pw = st_q.sense_sync[1]; // see [RULE1] see [RULE12]
        else
            st_d.self_pw = power_source_select;
        // outputs follow the mode in force now
        st_d.port_off = st_q.self_pw ? st_q.self_off[2:1] : st_q.bus_off[2:1]; // see [RULE6] see [RULE7] see [RULE13]
        st_d.limit    = st_q.self_pw ? st_q.self_limit : st_q.bus_limit; // see [RULE13]
        st_d.compound = st_q.options[hub_cfg_pkg::COMPOUND_BIT]; // see [RULE3]
        st_d.fixed    = st_q.fixed_ports[2:1]; // see [RULE4]
        // readback is registered, one cycle behind the address
        unique case (cfg_addr)
            hub_cfg_pkg::OFF_HUB_OPTIONS_TWO:     st_d.rdata = st_q.options;
            hub_cfg_pkg::OFF_FIXED_DEVICE_PORTS:  st_d.rdata = st_q.fixed_ports;
            hub_cfg_pkg::OFF_PORT_OFF_SELF_POWER: st_d.rdata = st_q.self_off;
            hub_cfg_pkg::OFF_PORT_OFF_BUS_POWER:  st_d.rdata = st_q.bus_off;
            hub_cfg_pkg::OFF_POWER_LIMIT_SELF:    st_d.rdata = st_q.self_limit;
            hub_cfg_pkg::OFF_POWER_LIMIT_BUS:     st_d.rdata = st_q.bus_limit;
            default:                              st_d.rdata = 8'h00;
        endcase
        // overcurrent qualification: fault only after the selected delay
        if (!oc_raw) begin
            st_d.oc_cnt   = 32'h0;
            st_d.oc_fault = 1'b0;
        end else if (st_q.oc_cnt + 32'h1 >= oc_target) begin
            st_d.oc_fault = 1'b1; // see [RULE2]
        end else begin
            st_d.oc_cnt = st_q.oc_cnt + 32'h1;
        end
    end

    // single state register; reset to documented byte defaults
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q             <= '0;
            st_q.options     <= hub_cfg_pkg::RST_HUB_OPTIONS_TWO;
            st_q.fixed_ports <= hub_cfg_pkg::RST_FIXED_DEVICE_PORTS;
            st_q.self_off    <= hub_cfg_pkg::RST_PORT_OFF_SELF_POWER;
            st_q.bus_off     <= hub_cfg_pkg::RST_PORT_OFF_BUS_POWER;
            st_q.self_limit  <= hub_cfg_pkg::RST_POWER_LIMIT_SELF;
            st_q.bus_limit   <= hub_cfg_pkg::RST_POWER_LIMIT_BUS;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign cfg_rdata              = st_q.rdata;
    assign self_powered           = st_q.self_pw;
    assign compound_device        = st_q.compound;
    assign fixed_device_port_mask = st_q.fixed;
    assign port_off               = st_q.port_off;
    assign current_limit          = st_q.limit;
    assign oc_fault               = st_q.oc_fault;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_rsvd_port_bits: assert property (@(posedge mclk) disable iff (srst) // see [RULE5]
        (st_q.fixed_ports[0] == 1'b0) && (st_q.fixed_ports[7:3] == 5'h0))
        else $error("reserved port bits not zero");
    a_self_off_sel: assert property (@(posedge mclk) disable iff (srst) // see [RULE6]
        st_q.self_pw |=> (port_off == $past(st_q.self_off[2:1])))
        else $error("self mode port disable wrong");
    a_bus_off_sel: assert property (@(posedge mclk) disable iff (srst) // see [RULE7]
        !st_q.self_pw |=> (port_off == $past(st_q.bus_off[2:1])))
        else $error("bus mode port disable wrong");
    a_self_limit: assert property (@(posedge mclk) disable iff (srst) // see [RULE8]
        st_q.self_pw |=> (current_limit == $past(st_q.self_limit)))
        else $error("self limit wrong");
    a_bus_limit: assert property (@(posedge mclk) disable iff (srst) // see [RULE9]
        !st_q.self_pw |=> (current_limit == $past(st_q.bus_limit)))
        else $error("bus limit wrong");
    a_static_mode: assert property (@(posedge mclk) disable iff (srst) // see [RULE1]
        !st_q.options[hub_cfg_pkg::DYNAMIC_BIT] |=> (self_powered == $past(power_source_select)))
        else $error("static mode not following select");
    a_dynamic_sense: assert property (@(posedge mclk) disable iff (srst) // see [RULE12]
        st_q.options[hub_cfg_pkg::DYNAMIC_BIT] |=> (self_powered == $past(st_q.sense_sync[1])))
        else $error("dynamic mode not following sense");
    a_compound_flag: assert property (@(posedge mclk) disable iff (srst) // see [RULE3]
        ##1 (compound_device == $past(st_q.options[hub_cfg_pkg::COMPOUND_BIT])))
        else $error("compound flag wrong");
    a_fixed_ports: assert property (@(posedge mclk) disable iff (srst) // see [RULE4]
        ##1 (fixed_device_port_mask == $past(st_q.fixed_ports[2:1])))
        else $error("fixed port mask wrong");
    a_oc_quiet: assert property (@(posedge mclk) disable iff (srst) // see [RULE2]
        !oc_raw |=> !oc_fault)
        else $error("fault without overcurrent");

    ////////////////////////////////////////////////////////////////////
    // building blocks for the multi-step checks below
    sequence s_wr_at(logic [7:0] a);
        cfg_wr && (cfg_addr == a);
    endsequence
    sequence s_oc_counting;
        oc_raw && (st_q.oc_cnt + 32'h1 < oc_target);
    endsequence
    sequence s_oc_reached;
        oc_raw && (st_q.oc_cnt + 32'h1 >= oc_target);
    endsequence
    sequence s_mode_flip;
        $changed(self_powered);
    endsequence

    // write path: each byte lands one edge after its strobe, options and port bytes masked, limit bytes as sent
    a_opt_write: assert property (@(posedge mclk) disable iff (srst) // see [RULE1]
        s_wr_at(hub_cfg_pkg::OFF_HUB_OPTIONS_TWO) |=>
        (st_q.options == ($past(cfg_wdata) & hub_cfg_pkg::OPTIONS_MASK)))
        else $error("options byte write lost");
    a_fixed_write: assert property (@(posedge mclk) disable iff (srst) // see [RULE4]
        s_wr_at(hub_cfg_pkg::OFF_FIXED_DEVICE_PORTS) |=>
        (st_q.fixed_ports == ($past(cfg_wdata) & hub_cfg_pkg::PORT_BITS_MASK)))
        else $error("fixed port byte write lost");
    a_self_off_write: assert property (@(posedge mclk) disable iff (srst) // see [RULE6]
        s_wr_at(hub_cfg_pkg::OFF_PORT_OFF_SELF_POWER) |=>
        (st_q.self_off == ($past(cfg_wdata) & hub_cfg_pkg::PORT_BITS_MASK)))
        else $error("self disable byte write lost");
    a_bus_off_write: assert property (@(posedge mclk) disable iff (srst) // see [RULE7]
        s_wr_at(hub_cfg_pkg::OFF_PORT_OFF_BUS_POWER) |=>
        (st_q.bus_off == ($past(cfg_wdata) & hub_cfg_pkg::PORT_BITS_MASK)))
        else $error("bus disable byte write lost");
    a_self_lim_write: assert property (@(posedge mclk) disable iff (srst) // see [RULE8]
        s_wr_at(hub_cfg_pkg::OFF_POWER_LIMIT_SELF) |=>
        (st_q.self_limit == $past(cfg_wdata)))
        else $error("self limit write lost");
    a_bus_lim_write: assert property (@(posedge mclk) disable iff (srst) // see [RULE9]
        s_wr_at(hub_cfg_pkg::OFF_POWER_LIMIT_BUS) |=>
        (st_q.bus_limit == $past(cfg_wdata)))
        else $error("bus limit write lost");

    // readback: the byte addressed on one edge shows on the next
    // registered on purpose, so the loader sees a clean one-cycle latency
    a_read_options: assert property (@(posedge mclk) disable iff (srst) // see [RULE1]
        (cfg_addr == hub_cfg_pkg::OFF_HUB_OPTIONS_TWO) |=>
        (cfg_rdata == $past(st_q.options)))
        else $error("options readback wrong");
    a_read_fixed: assert property (@(posedge mclk) disable iff (srst) // see [RULE4]
        (cfg_addr == hub_cfg_pkg::OFF_FIXED_DEVICE_PORTS) |=>
        (cfg_rdata == $past(st_q.fixed_ports)))
        else $error("fixed port readback wrong");
    a_read_self_off: assert property (@(posedge mclk) disable iff (srst) // see [RULE6]
        (cfg_addr == hub_cfg_pkg::OFF_PORT_OFF_SELF_POWER) |=>
        (cfg_rdata == $past(st_q.self_off)))
        else $error("self disable readback wrong");
    a_read_bus_off: assert property (@(posedge mclk) disable iff (srst) // see [RULE7]
        (cfg_addr == hub_cfg_pkg::OFF_PORT_OFF_BUS_POWER) |=>
        (cfg_rdata == $past(st_q.bus_off)))
        else $error("bus disable readback wrong");
    a_read_self_lim: assert property (@(posedge mclk) disable iff (srst) // see [RULE8]
        (cfg_addr == hub_cfg_pkg::OFF_POWER_LIMIT_SELF) |=>
        (cfg_rdata == $past(st_q.self_limit)))
        else $error("self limit readback wrong");
    a_read_bus_lim: assert property (@(posedge mclk) disable iff (srst) // see [RULE9]
        (cfg_addr == hub_cfg_pkg::OFF_POWER_LIMIT_BUS) |=>
        (cfg_rdata == $past(st_q.bus_limit)))
        else $error("bus limit readback wrong");
    a_read_unmapped: assert property (@(posedge mclk) disable iff (srst) // see [RULE5]
        ((cfg_addr < hub_cfg_pkg::OFF_HUB_OPTIONS_TWO) || (cfg_addr > hub_cfg_pkg::OFF_POWER_LIMIT_BUS)) |=>
        (cfg_rdata == 8'h00))
        else $error("unmapped readback not zero");

    // reserved bits never hold a one, whatever the loader sent
    a_rsvd_options: assert property (@(posedge mclk) disable iff (srst) // see [RULE3]
        ((st_q.options & ~hub_cfg_pkg::OPTIONS_MASK) == 8'h00))
        else $error("reserved options bits set");
    a_rsvd_self_off: assert property (@(posedge mclk) disable iff (srst) // see [RULE5]
        ((st_q.self_off & ~hub_cfg_pkg::PORT_BITS_MASK) == 8'h00))
        else $error("reserved self disable bits set");
    a_rsvd_bus_off: assert property (@(posedge mclk) disable iff (srst) // see [RULE5]
        ((st_q.bus_off & ~hub_cfg_pkg::PORT_BITS_MASK) == 8'h00))
        else $error("reserved bus disable bits set");

    // sense pin passes both flops before the mode logic reads it
    a_sense_chain: assert property (@(posedge mclk) disable iff (srst) // see [RULE12]
        1'b1 |=> (st_q.sense_sync[1] == $past(st_q.sense_sync[0])))
        else $error("sense synchroniser skipped a stage");

    // overcurrent: count while held, fault only once the delay is met
    a_oc_counting: assert property (@(posedge mclk) disable iff (srst) // see [RULE2]
        s_oc_counting |=> (st_q.oc_cnt == $past(st_q.oc_cnt) + 32'h1))
        else $error("overcurrent counter stalled");
    a_oc_raise: assert property (@(posedge mclk) disable iff (srst) // see [RULE2]
        s_oc_reached |=> oc_fault)
        else $error("fault missing after delay");
    a_oc_early: assert property (@(posedge mclk) disable iff (srst) // see [RULE2]
        $rose(oc_fault) |-> ($past(st_q.oc_cnt) + 32'h1 >= $past(oc_target)))
        else $error("fault raised before delay");

    // a mode change swaps both the disables and the current figure
    a_mode_ports: assert property (@(posedge mclk) disable iff (srst) // see [RULE13]
        s_mode_flip |=> (port_off == ($past(self_powered) ? $past(st_q.self_off[2:1]) : $past(st_q.bus_off[2:1]))))
        else $error("port disables not swapped");
    a_mode_limit: assert property (@(posedge mclk) disable iff (srst) // see [RULE13]
        s_mode_flip |=> (current_limit == ($past(self_powered) ? $past(st_q.self_limit) : $past(st_q.bus_limit))))
        else $error("current figure not swapped");
endmodule : hub_power_port_config_bytes

// File: pkg/hub_cfg_pkg.sv
// constants for the power and port configuration byte bank
package hub_cfg_pkg;
    // byte offsets within the configuration image
    localparam logic [7:0] OFF_HUB_OPTIONS_TWO      = 8'h07;
    localparam logic [7:0] OFF_FIXED_DEVICE_PORTS   = 8'h08;
    localparam logic [7:0] OFF_PORT_OFF_SELF_POWER  = 8'h09;
    localparam logic [7:0] OFF_PORT_OFF_BUS_POWER   = 8'h0A;
    localparam logic [7:0] OFF_POWER_LIMIT_SELF     = 8'h0B;
    localparam logic [7:0] OFF_POWER_LIMIT_BUS      = 8'h0C;
    // values after reset
    localparam logic [7:0] RST_HUB_OPTIONS_TWO      = 8'h90;
    localparam logic [7:0] RST_FIXED_DEVICE_PORTS   = 8'h00;
    localparam logic [7:0] RST_PORT_OFF_SELF_POWER  = 8'h00;
    localparam logic [7:0] RST_PORT_OFF_BUS_POWER   = 8'h00;
    localparam logic [7:0] RST_POWER_LIMIT_SELF     = 8'h01;
    localparam logic [7:0] RST_POWER_LIMIT_BUS      = 8'h64;
    // field positions in the options byte
    localparam int DYNAMIC_BIT   = 7;
    localparam int OC_SEL_LSB    = 4;
    localparam int COMPOUND_BIT  = 3;
    // port bits (port n sits at bit n), writable mask of port bytes
    localparam logic [7:0] PORT_BITS_MASK  = 8'h06;
    localparam logic [7:0] OPTIONS_MASK    = 8'hB8;
    // overcurrent delay figures, tenths of a millisecond, and cycle counts at 100 MHz
    localparam int CLK_HZ          = 100_000_000;
    localparam int OC_T0_100US     = 1;
    localparam int OC_T1_100US     = 20;
    localparam int OC_T2_100US     = 40;
    localparam int OC_T3_100US     = 60;
    localparam int OC_CYC0 = OC_T0_100US * (CLK_HZ / 10_000);
    localparam int OC_CYC1 = OC_T1_100US * (CLK_HZ / 10_000);
    localparam int OC_CYC2 = OC_T2_100US * (CLK_HZ / 10_000);
    localparam int OC_CYC3 = OC_T3_100US * (CLK_HZ / 10_000);
endpackage : hub_cfg_pkg

// File: tb/cfg_loader.sv
// loader model writing configuration bytes into the bank
module cfg_loader (
    // clock
    input  wire logic       mclk,
    // byte port toward the bank
    output logic            cfg_wr,
    output logic      [7:0] cfg_addr,
    output logic      [7:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle values at time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
    end
    // one byte write; released data shows the inverse so stale bytes never look valid
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == hub_cfg_pkg::OFF_POWER_LIMIT_SELF && v > 8'h32) begin
            v = 8'h32;
        end
        @(negedge mclk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= v;
        @(negedge mclk);
        cfg_wr <= 1'b0;
        cfg_wdata <= ~v;
    endtask : write_byte
    // readback address only
    task automatic point(input logic [7:0] a);
        @(negedge mclk);
        cfg_addr <= a;
    endtask : point
endmodule : cfg_loader

// File: tb/hub_power_port_config_bytes_tb.sv
// self-checking bench for the power and port configuration bank
module hub_power_port_config_bytes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk, srst, cfg_wr, power_source_select, local_power_sense_pin, oc_raw, self_powered, compound_device;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, current_limit, e, d, w;
    logic [2:1] fixed_device_port_mask, port_off;
    logic [7:0] exp_q[$];
    logic [7:0] offs[6] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    logic [7:0] rsts[6] = '{8'h90, 8'h00, 8'h00, 8'h00, 8'h01, 8'h64};
    logic [7:0] msks[6] = '{8'hB8, 8'h06, 8'h06, 8'h06, 8'hFF, 8'hFF};
    int         n_errors = 0, n_compared = 0, probe = 0, cyc = 0, seed = 34, n;
    logic       chk_en = 1'b0, sp;
    logic [2:1] fx;
    wire        oc_fault_w;
    wire  [47:0] obs = {3'h0, compound_device, 2'h0, fixed_device_port_mask, 7'h0, oc_fault_w, 7'h0, self_powered,
                        6'h0, port_off, current_limit, cfg_rdata};
    cfg_loader ld (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
    hub_power_port_config_bytes #(.OC_CYC_0(2), .OC_CYC_1(4), .OC_CYC_2(6), .OC_CYC_3(8)) dut (
        .mclk(mclk), .srst(srst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .power_source_select(power_source_select),
        .local_power_sense_pin(local_power_sense_pin), .oc_raw(oc_raw), .self_powered(self_powered),
        .compound_device(compound_device), .fixed_device_port_mask(fixed_device_port_mask),
        .port_off(port_off), .current_limit(current_limit), .oc_fault(oc_fault_w));
    // 100 MHz clock
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    // note an expectation; the watcher compares at the next rising edge
    task automatic chk(input logic [7:0] x, input int p);
        exp_q.push_back(x);
        probe = p;
        chk_en = 1'b1;
        @(posedge mclk);
        #1;
        chk_en = 1'b0;
        @(negedge mclk);
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        ld.point(a);
        repeat (2) @(negedge mclk);
        chk(x, 0);
    endtask : rd
    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // watcher and hang guard, ceiling well above the few hundred cycles used
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            n_errors++;
            report_and_stop();
        end
        if (chk_en) begin
            w = exp_q.pop_front();
            n_compared++;
            if (obs[probe*8 +: 8] !== w) begin
                n_errors++;
                $display("[ERR] %0t probe %0d got %h want %h", $time, probe, obs[probe*8 +: 8], w);
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        power_source_select = 1'b0;
        local_power_sense_pin = 1'b0;
        oc_raw = 1'b0;
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        // reset values, an unmapped byte, then random writes with reserved bits dropped
        for (int i = 0; i < 6; i++) rd(offs[i], rsts[i]);
        rd(8'h0D, 8'h00);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            ld.write_byte(offs[i], d);
            e = d & msks[i];
            if (i == 4 && e > 8'h32) e = 8'h32;
            if (i == 1) fx = e[2:1];
            rd(offs[i], e);
        end
        ld.write_byte(8'h09, 8'h02);
        ld.write_byte(8'h0A, 8'h04);
        ld.write_byte(8'h0B, 8'h32); // figure already counts the embedded peripheral
        ld.write_byte(8'h0C, 8'h64);
        // every delay code, compound flag and dynamic switch against both power sources
        for (int k = 0; k < 4; k++) begin
            ld.write_byte(8'h07, {k[1], 1'b0, k[1:0], k[0], 3'h0});
            @(negedge mclk);
            chk({3'h0, k[0], 2'h0, fx}, 5);
            for (int m = 0; m < 4; m++) begin
                local_power_sense_pin = m[0];
                power_source_select = m[1];
                repeat (6) @(negedge mclk);
                sp = k[1] ? m[0] : m[1];
                chk({7'h0, sp}, 3);
                chk(sp ? 8'h01 : 8'h02, 2);
                chk(sp ? 8'h32 : 8'h64, 1);
            end
            n = 2 + 2 * k;
            oc_raw = 1'b1;
            repeat (n - 1) @(negedge mclk);
            chk(8'h00, 4);
            chk(8'h01, 4);
            oc_raw = 1'b0;
            repeat (3) @(negedge mclk);
        end
        report_and_stop();
    end
endmodule : hub_power_port_config_bytes_tb
